// ==== core/digital_io_port_block.sv ====
// digital_in_out port block: three 8-bit ports, port c split into halves
// assumes one 40 MHz clock, synchronous reset, pins asynchronous to the clock
`include "dio_map.svh"
`default_nettype none

module digital_io_port_block import dio_pkg::*; (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire avm_req_t i_bus,
    output logic [31:0] o_readdata,
    output logic o_waitrequest,
    input wire dio_lines_t i_line_level,
    output dio_lines_t o_line_drive,
    output dio_lines_t o_line_drive_en
);

    // ------------------------------------------------------------
    // selection decode
    // ------------------------------------------------------------
    function automatic logic port_ok(input logic [2:0] p);
        port_ok = (p <= 3'(port_one_c_high_half));
    endfunction

    function automatic logic port_half(input logic [2:0] p);
        port_half = (p == 3'(port_one_c_low_half)) || (p == 3'(port_one_c_high_half));
    endfunction

    function automatic logic [4:0] port_base(input logic [2:0] p);
        case (p)
            3'h1: port_base = 5'h08;
            3'h2: port_base = 5'h10;
            3'h3: port_base = 5'h10;
            3'h4: port_base = 5'h14;
            default: port_base = 5'h00;
        endcase
    endfunction

    // nibble lanes owned by a selection; none for an invalid code
    function automatic logic [5:0] port_nibs(input logic [2:0] p);
        case (p)
            3'h0: port_nibs = 6'h03;
            3'h1: port_nibs = 6'h0c;
            3'h2: port_nibs = 6'h30;
            3'h3: port_nibs = 6'h10;
            3'h4: port_nibs = 6'h20;
            default: port_nibs = 6'h00;
        endcase
    endfunction

    function automatic logic [23:0] expand(input logic [5:0] n);
        logic [23:0] v;
        v = 24'h000000;
        for (int k = 0; k < 6; k++) begin
            v[k*4 +: 4] = {4{n[k]}};
        end
        expand = v;
    endfunction

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    bus_state_t state;
    bus_state_t next_state;
    logic [7:0] sel;
    logic [5:0] dir_nib;
    logic [23:0] out_store;
    logic [23:0] pin_meta;
    logic [23:0] pin_sync;
    logic [1:0] err;
    logic [7:0] next_sel;
    logic [5:0] next_dir;
    logic [23:0] next_out;
    logic [1:0] next_err;
    logic [31:0] next_readdata;
    logic [23:0] dir_lanes;

    // ------------------------------------------------------------
    // named decode wires
    // ------------------------------------------------------------
    wire [2:0] sel_port = sel[`DIO_SEL_PORT_LSB +: 3];
    wire [3:0] sel_line = sel[`DIO_SEL_LINE_LSB +: 4];
    wire port_valid = port_ok(sel_port);
    wire [3:0] line_top = port_half(sel_port) ? 4'h3 : 4'h7;
    wire line_valid = port_valid && (sel_line <= line_top);
    wire [4:0] base = port_base(sel_port);
    wire [5:0] sel_nibs = port_nibs(sel_port);
    wire [23:0] port_mask = expand(sel_nibs);
    // an invalid selection owns no lanes, so its port reads come back as zero
    wire [7:0] lane_mask = !port_valid ? 8'h00 :
        port_half(sel_port) ? 8'h0f : 8'hff;
    wire [23:0] pin_shift = pin_sync >> base;
    wire [23:0] out_shift = out_store >> base;
    wire [7:0] pin_port = pin_shift[7:0] & lane_mask;
    wire [7:0] out_port = out_shift[7:0] & lane_mask;
    wire line_pin = line_valid & pin_shift[sel_line[2:0]];
    wire line_out = line_valid & out_shift[sel_line[2:0]];
    wire [4:0] line_pos = base + {2'h0, sel_line[2:0]};
    wire [23:0] line_bit = line_valid ? (24'h000001 << line_pos) : 24'h000000;

    wire req = i_bus.read | i_bus.write;
    wire taking = (state == st_ack);
    wire wr = taking & i_bus.write;
    wire hit_sel = (i_bus.address == `DIO_OFF_SELECT);
    wire hit_dir = (i_bus.address == `DIO_OFF_DIR);
    wire hit_pin = (i_bus.address == `DIO_OFF_PORT_IN);
    wire hit_out = (i_bus.address == `DIO_OFF_PORT_OUT);
    wire hit_lpin = (i_bus.address == `DIO_OFF_LINE_IN);
    wire hit_lout = (i_bus.address == `DIO_OFF_LINE_OUT);
    wire hit_stat = (i_bus.address == `DIO_OFF_STATUS);
    wire wd_level = i_bus.writedata[0];
    wire [7:0] wd_byte = i_bus.writedata[7:0] & lane_mask;

    // whole-port write keeps other ports; line write reuses the stored value
    wire [23:0] put_port = (out_store & ~port_mask) | ({16'h0000, wd_byte} << base);
    wire [23:0] put_line = wd_level ? (out_store | line_bit) : (out_store & ~line_bit);

    wire bad_port = taking && (hit_dir || hit_pin || hit_out) && !port_valid;
    wire bad_line = taking && (hit_lpin || hit_lout) && !line_valid;
    wire [1:0] err_set = {bad_line, bad_port};
    wire [1:0] err_clr = (wr && hit_stat) ? i_bus.writedata[1:0] : 2'h0;

    // ------------------------------------------------------------
    // next values
    // ------------------------------------------------------------
    assign next_state = (state == st_idle && req) ? st_ack : st_idle;
    assign next_sel = (wr && hit_sel) ? i_bus.writedata[7:0] : sel;
    assign next_dir = !(wr && hit_dir) ? dir_nib :
        (wd_level ? (dir_nib | sel_nibs) : (dir_nib & ~sel_nibs));
    // stored value updates whatever the direction; only the enable gates the pin
    assign next_out = (wr && hit_out && port_valid) ? put_port :
        (wr && hit_lout && line_valid) ? put_line : out_store;
    // a new error wins over a clear in the same cycle
    assign next_err = (err & ~err_clr) | err_set;

    assign next_readdata =
        hit_sel ? {24'h000000, sel} :
        hit_dir ? {26'h0000000, dir_nib} :
        hit_pin ? {24'h000000, pin_port} :
        hit_out ? {24'h000000, out_port} :
        hit_lpin ? {31'h00000000, line_pin} :
        hit_lout ? {31'h00000000, line_out} :
        hit_stat ? {30'h00000000, err} : 32'h00000000;

    // ------------------------------------------------------------
    // direction lanes
    // ------------------------------------------------------------
    for (genvar g = 0; g < 6; g++) begin : g_lane
        assign dir_lanes[g*4 +: 4] = {4{next_dir[g]}};
    end

    // ------------------------------------------------------------
    // pin synchroniser
    // ------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        pin_meta <= i_line_level;
        pin_sync <= pin_meta;
    end

    // ------------------------------------------------------------
    // bus slave and registers
    // ------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            state <= st_idle;
            o_waitrequest <= 1'b1;
            o_readdata <= 32'h00000000;
        end else begin
            state <= next_state;
            o_waitrequest <= (next_state != st_ack);
            o_readdata <= (state == st_idle && i_bus.read) ? next_readdata : o_readdata;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            sel <= `DIO_RST_SEL;
            dir_nib <= `DIO_RST_DIR;
            out_store <= `DIO_RST_OUT;
            err <= `DIO_RST_ERR;
        end else begin
            sel <= next_sel;
            dir_nib <= next_dir;
            out_store <= next_out;
            err <= next_err;
        end
    end

    // outputs follow the next values so they leave straight from flops
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_line_drive <= dio_lines_t'(`DIO_RST_OUT);
            o_line_drive_en <= dio_lines_t'(24'h000000);
        end else begin
            o_line_drive <= dio_lines_t'(next_out);
            o_line_drive_en <= dio_lines_t'(dir_lanes);
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    sequence s_accept;
        !o_waitrequest ##1 o_waitrequest;
    endsequence

    sequence s_idle_read(h);
        state == st_idle && i_bus.read && h;
    endsequence

    sequence s_zero_answer;
        o_readdata == 32'h00000000;
    endsequence

    bus_answer_a: assert property (state == st_idle && req |=> s_accept)
        else $error("bus answer not one cycle");

    port_read_a: assert property (s_idle_read(hit_pin && port_valid) |=>
        o_readdata == {24'h000000, $past(pin_port)})
        else $error("port read differs from synced pins");

    bad_line_a: assert property (bad_line |=> err[1])
        else $error("invalid line not flagged");

    line_read_a: assert property (s_idle_read(hit_lpin) |=>
        o_readdata[31:1] == 31'h00000000 && o_readdata[0] == $past(line_pin))
        else $error("line read not one bit");

    dir_write_a: assert property (wr && hit_dir && port_valid |=>
        (dir_nib & $past(sel_nibs)) == ($past(wd_level) ? $past(sel_nibs) : 6'h00))
        else $error("direction not applied to port");

    bad_port_a: assert property (wr && hit_out && !port_valid |=>
        out_store == $past(out_store) && err[0])
        else $error("invalid port accepted");

    readback_a: assert property (s_idle_read(hit_out && port_valid) |=>
        o_readdata[7:0] == $past(out_port))
        else $error("read-back differs from stored value");

    line_back_a: assert property (s_idle_read(hit_lout) |=>
        o_readdata[0] == $past(line_out))
        else $error("line read-back wrong");

    line_keep_a: assert property (wr && hit_lout && line_valid |=>
        ((out_store ^ $past(out_store)) & ~$past(line_bit)) == 24'h000000 &&
        ((out_store & $past(line_bit)) != 24'h000000) == $past(wd_level))
        else $error("line write disturbed other lines");

    input_off_a: assert property (wr && hit_dir && port_valid && !wd_level |=>
        (o_line_drive_en & $past(port_mask)) == 24'h000000)
        else $error("input port still driven");

    bad_port_rd_a: assert property (s_idle_read((hit_pin || hit_out) && !port_valid) |=>
        s_zero_answer)
        else $error("invalid port read not zero");

    bad_line_rd_a: assert property (s_idle_read((hit_lpin || hit_lout) && !line_valid) |=>
        s_zero_answer)
        else $error("invalid line read not zero");

    unmapped_read_a: assert property (s_idle_read(i_bus.address > `DIO_OFF_STATUS || i_bus.address[1:0] != 2'h0) |=>
        s_zero_answer)
        else $error("unmapped read not zero");

    bad_line_keep_a: assert property (wr && hit_lout && !line_valid |=>
        out_store == $past(out_store))
        else $error("invalid line write changed output");

    half_line_a: assert property (taking && (hit_lpin || hit_lout) && port_half(sel_port) && sel_line[2] |=>
        err[1])
        else $error("line above half not flagged");

    err_clear_a: assert property (wr && hit_stat |=>
        (err & $past(i_bus.writedata[1:0])) == 2'h0)
        else $error("status bit not cleared");

    out_keep_a: assert property (wr && hit_out && port_valid |=>
        ((out_store ^ $past(out_store)) & ~$past(port_mask)) == 24'h000000)
        else $error("port write disturbed other ports");

    half_read_a: assert property (s_idle_read(hit_pin && port_half(sel_port)) |=>
        o_readdata[31:4] == 28'h0000000)
        else $error("half port read wider than four bits");

    drive_store_a: assert property (o_line_drive == out_store)
        else $error("driven value differs from stored value");

    drive_dir_a: assert property (o_line_drive_en == expand(dir_nib))
        else $error("enables differ from direction");

    idle_wait_a: assert property (state == st_idle && !req |=> o_waitrequest)
        else $error("answer without request");

    ack_once_a: assert property (state == st_ack |=> state == st_idle && o_waitrequest)
        else $error("answer held past one cycle");

    sel_write_a: assert property (wr && hit_sel |=> sel == $past(i_bus.writedata[7:0]))
        else $error("select not written");

endmodule

`default_nettype wire

// ==== core/dio_map.svh ====
// register offsets, field positions and reset values of the digital port block
// assumes byte addressing on a 32-bit Avalon-MM slave, one register per word
`ifndef DIO_MAP_SVH
`define DIO_MAP_SVH

// ------------------------------------------------------------
// register offsets
// ------------------------------------------------------------
`define DIO_OFF_SELECT 5'h00
`define DIO_OFF_DIR 5'h04
`define DIO_OFF_PORT_IN 5'h08
`define DIO_OFF_PORT_OUT 5'h0c
`define DIO_OFF_LINE_IN 5'h10
`define DIO_OFF_LINE_OUT 5'h14
`define DIO_OFF_STATUS 5'h18

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define DIO_SEL_PORT_LSB 0
`define DIO_SEL_LINE_LSB 4
`define DIO_ST_BAD_PORT 0
`define DIO_ST_BAD_LINE 1

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define DIO_RST_SEL 8'h00
`define DIO_RST_DIR 6'h00
`define DIO_RST_OUT 24'h000000
`define DIO_RST_ERR 2'h0

`endif

// ==== core/dio_pkg.sv ====
// types shared by the digital port block
// assumes nothing beyond the map header
`default_nettype none

package dio_pkg;

    // ------------------------------------------------------------
    // port selection codes
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        port_one_a = 3'h0,
        port_one_b = 3'h1,
        port_one_c = 3'h2,
        port_one_c_low_half = 3'h3,
        port_one_c_high_half = 3'h4
    } port_id_t;

    typedef enum logic [1:0] {
        st_idle = 2'h1,
        st_ack = 2'h2
    } bus_state_t;

    typedef struct packed {
        logic read;
        logic write;
        logic [4:0] address;
        logic [31:0] writedata;
    } avm_req_t;

    typedef struct packed {
        logic [7:0] port_one_c;
        logic [7:0] port_one_b;
        logic [7:0] port_one_a;
    } dio_lines_t;

endpackage

`default_nettype wire

// ==== dv/dio_pins.sv ====
// pin model of the attached equipment's digital lines
// assumes per-line drive and enable from the block; undriven lines follow i_ext
`default_nettype none

module dio_pins import dio_pkg::*; (
    input wire dio_lines_t i_drive,
    input wire dio_lines_t i_drive_en,
    input wire dio_lines_t i_ext,
    output dio_lines_t o_level
);
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------
    // wire level
    // ------------------------------------------------------------
    // a driven line shows the block's value, a released one the equipment's
    assign o_level = dio_lines_t'((i_drive & i_drive_en) | (i_ext & ~i_drive_en));
endmodule

`default_nettype wire

// ==== dv/tb_digital_io_port_block.sv ====
// testbench of the digital port block: bus tasks, pin model, self checks
// assumes the one-cycle waitrequest answer and two-flop pin sync of the block
`include "dio_map.svh"
`default_nettype none

module tb_digital_io_port_block import dio_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_clk = 1'b0;
    logic i_rst = 1'b1;
    avm_req_t i_bus = '0;
    logic [31:0] o_readdata;
    logic o_waitrequest;
    dio_lines_t level, o_line_drive, o_line_drive_en;
    dio_lines_t ext = 24'h5ac396;
    logic [31:0] rdata;
    int failures = 0;
    int compares = 0;

    always #12.5 i_clk = ~i_clk;

    digital_io_port_block digital_io_port_block_i (.i_clk(i_clk), .i_rst(i_rst), .i_bus(i_bus),
        .o_readdata(o_readdata), .o_waitrequest(o_waitrequest), .i_line_level(level),
        .o_line_drive(o_line_drive), .o_line_drive_en(o_line_drive_en));
    dio_pins dio_pins_i (.i_drive(o_line_drive), .i_drive_en(o_line_drive_en), .i_ext(ext), .o_level(level));

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic give_verdict();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // request held until the edge that samples waitrequest low
    task automatic access(input logic rd, input logic [4:0] adr, input logic [31:0] wd);
        int n;
        @(posedge i_clk);
        i_bus <= '{read: rd, write: ~rd, address: adr, writedata: wd};
        n = 0;
        do begin
            @(posedge i_clk);
            n++;
        end while (o_waitrequest !== 1'b0 && n < 20);
        rdata = o_readdata;
        i_bus <= '0;
        if (n >= 20) begin
            failures++;
            give_verdict();
        end
    endtask

    task automatic wr(input logic [4:0] adr, input logic [31:0] d);
        access(1'b0, adr, d);
    endtask

    task automatic rd_chk(input logic [4:0] adr, input logic [31:0] exp);
        access(1'b1, adr, 32'h0);
        chk(rdata, exp);
    endtask

    function automatic logic [31:0] sel(input logic [2:0] p, input logic [3:0] ln);
        return {24'h0, ln, 1'b0, p};
    endfunction

    // ------------------------------------------------------------
    // sequence
    // ------------------------------------------------------------
    initial begin
        repeat (2) @(posedge i_clk);
        i_rst <= 1'b0;
        rd_chk(`DIO_OFF_DIR, 32'h0);
        rd_chk(`DIO_OFF_STATUS, 32'h0);
        chk({8'h0, o_line_drive_en}, 32'h0);
        wr(`DIO_OFF_SELECT, sel(port_one_a, 4'h0));
        wr(`DIO_OFF_DIR, 32'h1);
        wr(`DIO_OFF_PORT_OUT, 32'ha5);
        rd_chk(`DIO_OFF_PORT_OUT, 32'ha5);
        chk({8'h0, o_line_drive_en}, 32'hff);
        chk({24'h0, o_line_drive.port_one_a}, 32'ha5);
        repeat (3) @(posedge i_clk);
        rd_chk(`DIO_OFF_PORT_IN, 32'ha5);
        wr(`DIO_OFF_LINE_OUT, 32'h0);
        rd_chk(`DIO_OFF_PORT_OUT, 32'ha4);
        rd_chk(`DIO_OFF_LINE_OUT, 32'h0);
        wr(`DIO_OFF_SELECT, sel(port_one_a, 4'h6));
        wr(`DIO_OFF_LINE_OUT, 32'h1);
        rd_chk(`DIO_OFF_LINE_OUT, 32'h1);
        rd_chk(`DIO_OFF_PORT_OUT, 32'he4);
        // input port: stored value moves, pins stay released
        wr(`DIO_OFF_SELECT, sel(port_one_b, 4'h0));
        wr(`DIO_OFF_PORT_OUT, 32'h3c);
        rd_chk(`DIO_OFF_PORT_OUT, 32'h3c);
        chk({24'h0, o_line_drive_en.port_one_b}, 32'h0);
        rd_chk(`DIO_OFF_PORT_IN, 32'hc3);
        ext.port_one_b <= 8'h69;
        repeat (3) @(posedge i_clk);
        for (int i = 0; i < 8; i++) begin
            wr(`DIO_OFF_SELECT, sel(port_one_b, 4'(i)));
            rd_chk(`DIO_OFF_LINE_IN, {31'h0, ext.port_one_b[i]});
        end
        // halves of port c
        wr(`DIO_OFF_SELECT, sel(port_one_c_low_half, 4'h0));
        wr(`DIO_OFF_DIR, 32'h1);
        wr(`DIO_OFF_PORT_OUT, 32'h9);
        wr(`DIO_OFF_SELECT, sel(port_one_c_high_half, 4'h0));
        wr(`DIO_OFF_PORT_OUT, 32'h6);
        wr(`DIO_OFF_SELECT, sel(port_one_c, 4'h0));
        rd_chk(`DIO_OFF_PORT_OUT, 32'h69);
        rd_chk(`DIO_OFF_DIR, 32'h13);
        chk({8'h0, o_line_drive_en}, 32'h0f00ff);
        repeat (3) @(posedge i_clk);
        rd_chk(`DIO_OFF_PORT_IN, 32'h59);
        // refused selections
        wr(`DIO_OFF_SELECT, sel(3'h5, 4'h0));
        rd_chk(`DIO_OFF_PORT_IN, 32'h0);
        rd_chk(`DIO_OFF_STATUS, 32'h1);
        wr(`DIO_OFF_PORT_OUT, 32'hff);
        rd_chk(`DIO_OFF_PORT_OUT, 32'h0);
        wr(`DIO_OFF_SELECT, sel(port_one_c_low_half, 4'h4));
        rd_chk(`DIO_OFF_LINE_IN, 32'h0);
        rd_chk(`DIO_OFF_STATUS, 32'h3);
        wr(`DIO_OFF_STATUS, 32'h3);
        rd_chk(`DIO_OFF_STATUS, 32'h0);
        wr(`DIO_OFF_SELECT, sel(port_one_a, 4'h8));
        wr(`DIO_OFF_LINE_OUT, 32'h0);
        rd_chk(`DIO_OFF_STATUS, 32'h2);
        rd_chk(5'h1c, 32'h0);
        wr(`DIO_OFF_SELECT, sel(port_one_a, 4'h0));
        rd_chk(`DIO_OFF_PORT_OUT, 32'he4);
        // back to input: drivers off, stored value still updates
        wr(`DIO_OFF_DIR, 32'h0);
        wr(`DIO_OFF_PORT_OUT, 32'h11);
        chk({24'h0, o_line_drive_en.port_one_a}, 32'h0);
        rd_chk(`DIO_OFF_PORT_OUT, 32'h11);
        give_verdict();
    end
endmodule

`default_nettype wire
